// ===== logic/pmiq_pkg.sv
// Shared constants for the pin multiplexer and input qualifier block.
// Assumes a single system clock and an AHB-Lite register slave.
package pmiq_pkg;
  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int B_PINS    = 32;    // Bank B pin count
  localparam int C_PINS    = 24;    // Bank C pin count
  localparam int C_DATA    = 16;    // Bank C pins carrying bus data
  localparam int GROUP     = 8;     // Pins sharing one sample period
  localparam int N_GROUPS  = 4;     // Sample period fields
  localparam int PRD_W     = 8;     // Sample period field width
  localparam int CNT_W     = 9;     // Sample spacing counter width
  localparam int WIN_SHORT = 3;     // Short window samples
  localparam int WIN_LONG  = 6;     // Long window samples

  // ------------------------------------------------------------
  // Route and filter selector codes
  // ------------------------------------------------------------
  localparam logic [1:0] RT_GPIO  = 2'h0;  // General-purpose I/O
  localparam logic [1:0] RT_ONE   = 2'h1;  // periph_choice_one
  localparam logic [1:0] RT_TWO   = 2'h2;  // periph_choice_two
  localparam logic [1:0] RT_THREE = 2'h3;  // periph_choice_three
  localparam logic [1:0] FLT_SYNC = 2'h0;  // Synchronise only
  localparam logic [1:0] FLT_WIN3 = 2'h1;  // Three-sample window
  localparam logic [1:0] FLT_WIN6 = 2'h2;  // Six-sample window
  localparam logic [1:0] FLT_RAW  = 2'h3;  // No synchronisation

  // ------------------------------------------------------------
  // Register byte offsets and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_B_ROUTE_LO = 8'h00;  // bank_b_route_low
  localparam logic [7:0] OFS_B_ROUTE_HI = 8'h04;  // bank_b_route_high
  localparam logic [7:0] OFS_C_ROUTE_LO = 8'h08;  // bank_c_route_low
  localparam logic [7:0] OFS_C_ROUTE_HI = 8'h0C;  // bank_c_route_high
  localparam logic [7:0] OFS_B_FSEL_LO  = 8'h10;  // bank_b_filter_sel_low
  localparam logic [7:0] OFS_B_FSEL_HI  = 8'h14;  // bank_b_filter_sel_high
  localparam logic [7:0] OFS_B_CTRL     = 8'h18;  // bank_control
  localparam logic [7:0] OFS_B_DOUT     = 8'h1C;  // Bank B GPIO output
  localparam logic [7:0] OFS_B_DIR      = 8'h20;  // Bank B GPIO direction
  localparam logic [7:0] OFS_B_DIN      = 8'h24;  // Bank B qualified input
  localparam logic [7:0] OFS_C_DOUT     = 8'h28;  // Bank C GPIO output
  localparam logic [7:0] OFS_C_DIR      = 8'h2C;  // Bank C GPIO direction
  localparam logic [7:0] OFS_C_DIN      = 8'h30;  // Bank C synced input
  localparam logic [31:0] RST_REG       = 32'h0000_0000;  // All registers
  localparam logic [31:0] C_HI_MASK     = 32'h0000_FFFF;  // Eight 2-bit fields
  localparam logic [31:0] C_IO_MASK     = 32'h00FF_FFFF;  // 24 Bank C pins

  // ------------------------------------------------------------
  // AHB-Lite encodings
  // ------------------------------------------------------------
  localparam logic       HRESP_OKAY = 1'b0;   // Only response used
  localparam int         ADDR_W     = 8;      // Decoded address bits
endpackage

// ===== logic/pmiq_top.sv
// Pin multiplexer and input qualifier for Bank B (32 pins) and Bank C (24 pins).
// Assumes AHB-Lite master with single word transfers; pins are asynchronous.
//
// Functional notes
// - Bank B two-bit route per pin
// - I2C pins open-drain, never drive high
// - Bank C low codes 00/01 give GPIO
// - Bank C low codes 1x give bus data
// - Bank C high codes 00/01 give GPIO
// - Bank C high codes 1x drive address
// - Per-pin filter mode selector field
// - Filter selectors reset to synchronise-only
// - Window modes synchronise, then filter
// - Sample period shared by eight pins
// - Period sets sample spacing, two clocks per count
// - Window holds three or six samples
// - Output changes only on unanimous window
// - Mode 11 passes input unsynchronised
// - Unrouted peripheral input takes default level
// - Several pins may feed one input

// ------------------------------------------------------------
// Per-pin sampling window filter
// ------------------------------------------------------------
module pmiq_pin_filter
  import pmiq_pkg::*;
(
  input  wire logic       clk,      // System clock
  input  wire logic       rst_n,    // Synchronised reset, active low
  input  wire logic       din,      // Synchronised pin level
  input  wire logic       tick,     // Sample strobe of this group
  input  wire logic [1:0] mode,     // Filter mode of this pin
  output logic            qual      // Filtered level
);
  logic [WIN_LONG-1:0] win;         // Most recent sample in bit 0
  wire  short_one  = &win[WIN_SHORT-1:0];
  wire  short_zero = ~|win[WIN_SHORT-1:0];
  wire  long_one   = &win;
  wire  long_zero  = ~|win;
  wire  use_long   = (mode == FLT_WIN6);
  wire  all_one    = use_long ? long_one : short_one;
  wire  all_zero   = use_long ? long_zero : short_zero;

  // Shift in a sample on each strobe only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win <= '0;
    end else if (tick) begin
      win <= {win[WIN_LONG-2:0], din};
    end
  end
  // Follow the window only when every sample agrees
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qual <= 1'b0;
    end else if (all_one) begin
      qual <= 1'b1;
    end else if (all_zero) begin
      qual <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_flt_unanimous: assert property (!$stable(qual) |-> $past(all_one || all_zero))
    else $error("filtered level moved without unanimous window");
  a_flt_shift: assert property (tick |=> win[0] == $past(din))
    else $error("window did not take sample");
endmodule

// ------------------------------------------------------------
// Top level
// ------------------------------------------------------------
module pmiq_top
  import pmiq_pkg::*;
#(
  parameter logic [31:0] DEF_ONE    = 32'h0000_0000,  // Idle level, choice one inputs
  parameter logic [31:0] DEF_TWO    = 32'h0000_0000,  // Idle level, choice two inputs
  parameter logic [31:0] DEF_THREE  = 32'h0000_0000,  // Idle level, choice three inputs
  parameter logic [31:0] SHARE_MASK = 32'h0000_0024,  // Pins feeding the shared input
  parameter logic        DEF_SHARED = 1'b1            // Idle level of shared input
)(
  input  wire logic        CLK_SYS,       // System clock, 50 MHz
  input  wire logic        RST_N,         // Asynchronous reset, active low
  input  wire logic        HSEL,          // AHB slave select
  input  wire logic [31:0] HADDR,         // AHB address
  input  wire logic [1:0]  HTRANS,        // AHB transfer type
  input  wire logic        HWRITE,        // AHB write
  input  wire logic [2:0]  HSIZE,         // AHB size
  input  wire logic [31:0] HWDATA,        // AHB write data
  input  wire logic        HREADY,        // AHB bus ready
  output logic             HREADYOUT,     // Slave ready
  output logic             HRESP,         // Slave response
  output logic [31:0]      HRDATA,        // Read data
  input  wire logic [31:0] PB_IN,         // Bank B pin level
  output logic [31:0]      PB_OUT,        // Bank B pin drive value
  output logic [31:0]      PB_OE,         // Bank B pin drive enable
  input  wire logic [23:0] PC_IN,         // Bank C pin level
  output logic [23:0]      PC_OUT,        // Bank C pin drive value
  output logic [23:0]      PC_OE,         // Bank C pin drive enable
  input  wire logic [31:0] ONE_OUT,       // Choice one peripheral outputs
  input  wire logic [31:0] ONE_OE,        // Choice one peripheral enables
  output logic [31:0]      ONE_IN,        // Choice one peripheral inputs
  input  wire logic [31:0] TWO_OUT,       // Choice two peripheral outputs
  input  wire logic [31:0] TWO_OE,        // Choice two peripheral enables
  output logic [31:0]      TWO_IN,        // Choice two peripheral inputs
  input  wire logic [31:0] THREE_OUT,     // Choice three peripheral outputs
  input  wire logic [31:0] THREE_OE,      // Choice three peripheral enables
  output logic [31:0]      THREE_IN,      // Choice three peripheral inputs
  output logic             SHARED_IN,     // Input fed by several candidate pins
  input  wire logic [15:0] EXT_DATA_OUT,  // ext_bus_data from the bus unit
  input  wire logic [15:0] EXT_DATA_OE,   // ext_bus_data drive enables
  output logic [15:0]      EXT_DATA_IN,   // ext_bus_data to the bus unit
  input  wire logic [7:0]  EXT_ADDR_HI    // ext_bus_addr bits 15..8
);
  if (B_PINS != N_GROUPS * GROUP) begin : g_chk
    $error("bank B must split into whole sample groups");
  end

  // ------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------
  logic        rst_meta;              // First reset stage
  logic        rst_n;                 // Design reset
  logic [31:0] pb_meta;               // Bank B first stage
  logic [31:0] pb_sync;               // Bank B synchronised
  logic [23:0] pc_meta;               // Bank C first stage
  logic [23:0] pc_sync;               // Bank C synchronised

  // Release reset cleanly on the clock
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Two stages before logic sees a pin; bank B raw mode bypasses them
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pb_meta <= '0;
      pb_sync <= '0;
      pc_meta <= '0;
      pc_sync <= '0;
    end else begin
      pb_meta <= PB_IN;
      pb_sync <= pb_meta;
      pc_meta <= PC_IN;
      pc_sync <= pc_meta;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave and registers
  // ------------------------------------------------------------
  logic [31:0]       b_route_lo;      // bank_b_route_low
  logic [31:0]       b_route_hi;      // bank_b_route_high
  logic [31:0]       c_route_lo;      // bank_c_route_low
  logic [31:0]       c_route_hi;      // bank_c_route_high
  logic [31:0]       b_fsel_lo;       // bank_b_filter_sel_low
  logic [31:0]       b_fsel_hi;       // bank_b_filter_sel_high
  logic [31:0]       b_ctrl;          // bank_control, four period fields
  logic [31:0]       b_dout;          // Bank B GPIO output value
  logic [31:0]       b_dir;           // Bank B GPIO direction
  logic [31:0]       c_dout;          // Bank C GPIO output value
  logic [31:0]       c_dir;           // Bank C GPIO direction
  logic              wr_pend;         // Write data phase pending
  logic [ADDR_W-1:0] wr_addr;         // Latched write address
  logic [31:0]       b_qual;          // Bank B qualified levels
  logic [31:0]       rd_mux;          // Read selection
  wire               access = HSEL && HREADY && HTRANS[1];
  wire [ADDR_W-1:0]  a      = HADDR[ADDR_W-1:0];
  // Unmapped offsets read zero; writes to them are dropped
  assign rd_mux = (a == OFS_B_ROUTE_LO) ? b_route_lo :
                  (a == OFS_B_ROUTE_HI) ? b_route_hi :
                  (a == OFS_C_ROUTE_LO) ? c_route_lo :
                  (a == OFS_C_ROUTE_HI) ? c_route_hi :
                  (a == OFS_B_FSEL_LO)  ? b_fsel_lo  :
                  (a == OFS_B_FSEL_HI)  ? b_fsel_hi  :
                  (a == OFS_B_CTRL)     ? b_ctrl     :
                  (a == OFS_B_DOUT)     ? b_dout     :
                  (a == OFS_B_DIR)      ? b_dir      :
                  (a == OFS_B_DIN)      ? b_qual     :
                  (a == OFS_C_DOUT)     ? c_dout     :
                  (a == OFS_C_DIR)      ? c_dir      :
                  (a == OFS_C_DIN)      ? {8'h00, pc_sync} : 32'h0000_0000;

  // Zero wait states: every transfer completes in its data phase
  assign HREADYOUT = 1'b1;
  assign HRESP     = HRESP_OKAY;
  // Capture the write address and serve reads from the address phase
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      HRDATA  <= RST_REG;
    end else begin
      wr_pend <= access && HWRITE;
      wr_addr <= a;
      if (access && !HWRITE) begin
        HRDATA <= rd_mux;
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      b_route_lo <= RST_REG;
      b_route_hi <= RST_REG;
      c_route_lo <= RST_REG;
      c_route_hi <= RST_REG;
      b_fsel_lo  <= RST_REG;
      b_fsel_hi  <= RST_REG;
      b_ctrl     <= RST_REG;
      b_dout     <= RST_REG;
      b_dir      <= RST_REG;
      c_dout     <= RST_REG;
      c_dir      <= RST_REG;
    end else if (wr_pend) begin
      case (wr_addr)
        OFS_B_ROUTE_LO: b_route_lo <= HWDATA;
        OFS_B_ROUTE_HI: b_route_hi <= HWDATA;
        OFS_C_ROUTE_LO: c_route_lo <= HWDATA;
        OFS_C_ROUTE_HI: c_route_hi <= HWDATA & C_HI_MASK;
        OFS_B_FSEL_LO:  b_fsel_lo  <= HWDATA;
        OFS_B_FSEL_HI:  b_fsel_hi  <= HWDATA;
        OFS_B_CTRL:     b_ctrl     <= HWDATA;
        OFS_B_DOUT:     b_dout     <= HWDATA;
        OFS_B_DIR:      b_dir      <= HWDATA;
        OFS_C_DOUT:     c_dout     <= HWDATA & C_IO_MASK;
        OFS_C_DIR:      c_dir      <= HWDATA & C_IO_MASK;
        default: ;                     // Unmapped: ignored
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sample strobes, one divider per group of eight pins
  // ------------------------------------------------------------
  logic [N_GROUPS-1:0] tick;          // Sample strobe per group
  for (genvar g = 0; g < N_GROUPS; g++) begin : g_grp
    logic [CNT_W-1:0] cnt;            // Cycles since last sample
    wire  [PRD_W-1:0] prd  = b_ctrl[g*PRD_W +: PRD_W];
    wire  [CNT_W-1:0] span = {prd, 1'b0};                     // Twice the field
    wire              wrap = (cnt >= span - 9'h001);
    assign tick[g] = (prd == '0) || wrap;
    // Period zero samples every cycle; a shrinking period wraps at once
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
        cnt <= '0;
      end else if (tick[g]) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 9'h001;
      end
    end
  end

  // ------------------------------------------------------------
  // Bank B: route, qualify and feed peripherals
  // ------------------------------------------------------------
  logic [31:0] sel_one;               // Pin routed to choice one
  logic [31:0] sel_two;               // Pin routed to choice two
  logic [31:0] sel_three;             // Pin routed to choice three
  for (genvar i = 0; i < B_PINS; i++) begin : g_b
    wire [1:0] route = (i < 16) ? b_route_lo[2*(i%16) +: 2]
                                : b_route_hi[2*(i%16) +: 2];
    wire [1:0] mode  = (i < 16) ? b_fsel_lo[2*(i%16) +: 2]
                                : b_fsel_hi[2*(i%16) +: 2];
    logic      filt;                  // Window filtered level
    pmiq_pin_filter u_flt (
      .clk   (CLK_SYS),
      .rst_n (rst_n),
      .din   (pb_sync[i]),
      .tick  (tick[i/GROUP]),
      .mode  (mode),
      .qual  (filt)
    );
    // Raw mode bypasses both stages; the peripheral resynchronises
    assign b_qual[i] = (mode == FLT_RAW)  ? PB_IN[i]   :
                       (mode == FLT_SYNC) ? pb_sync[i] : filt;
    assign sel_one[i]   = (route == RT_ONE);
    assign sel_two[i]   = (route == RT_TWO);
    assign sel_three[i] = (route == RT_THREE);
    if (i < 2) begin : g_i2c
      // i2c_data_line and i2c_clock_line only ever pull low
      assign PB_OUT[i] = sel_one[i] ? 1'b0 : (route == RT_GPIO) ? b_dout[i] :
                         sel_two[i] ? TWO_OUT[i] : THREE_OUT[i];
      assign PB_OE[i]  = sel_one[i] ? ~ONE_OUT[i] : (route == RT_GPIO) ? b_dir[i] :
                         sel_two[i] ? TWO_OE[i] : THREE_OE[i];
    end else begin : g_std
      assign PB_OUT[i] = (route == RT_GPIO) ? b_dout[i] : sel_one[i] ? ONE_OUT[i] :
                         sel_two[i] ? TWO_OUT[i] : THREE_OUT[i];
      assign PB_OE[i]  = (route == RT_GPIO) ? b_dir[i] : sel_one[i] ? ONE_OE[i] :
                         sel_two[i] ? TWO_OE[i] : THREE_OE[i];
    end
  end

  // Unrouted peripheral inputs rest at their idle level
  assign ONE_IN   = (sel_one   & b_qual) | (~sel_one   & DEF_ONE);
  assign TWO_IN   = (sel_two   & b_qual) | (~sel_two   & DEF_TWO);
  assign THREE_IN = (sel_three & b_qual) | (~sel_three & DEF_THREE);

  // Shared input: the lowest candidate pin routed to choice one wins
  wire [31:0] cand     = SHARE_MASK & sel_one;
  wire [31:0] cand_low = cand & (~cand + 32'h0000_0001);
  assign SHARED_IN = (cand == '0) ? DEF_SHARED : |(cand_low & b_qual);

  // ------------------------------------------------------------
  // Bank C: bus data and address routing, synchronise only
  // ------------------------------------------------------------
  for (genvar i = 0; i < C_PINS; i++) begin : g_c
    if (i < C_DATA) begin : g_data
      wire bus = c_route_lo[2*i+1];
      assign PC_OUT[i] = bus ? EXT_DATA_OUT[C_DATA-1-i] : c_dout[i];
      assign PC_OE[i]  = bus ? EXT_DATA_OE[C_DATA-1-i]  : c_dir[i];
      assign EXT_DATA_IN[C_DATA-1-i] = bus & pc_sync[i];
    end else begin : g_addr
      wire bus = c_route_hi[2*(i-C_DATA)+1];
      assign PC_OUT[i] = bus ? EXT_ADDR_HI[i-C_DATA] : c_dout[i];
      assign PC_OE[i]  = bus | c_dir[i];
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);
  a_i2c_no_high: assert property (sel_one[0] |-> !PB_OUT[0] && PB_OE[0] == !ONE_OUT[0])
    else $error("i2c data pin drove high");
  a_b_gpio_route: assert property (b_route_lo[5:4] == RT_GPIO |->
                                   PB_OUT[2] == b_dout[2] && PB_OE[2] == b_dir[2])
    else $error("bank B pin 2 not on GPIO");
  a_b_three_route: assert property (b_route_hi[7:6] == RT_THREE |->
                                    PB_OUT[19] == THREE_OUT[19] && PB_OE[19] == THREE_OE[19])
    else $error("bank B pin 19 not on choice three");
  a_c_data_map: assert property (c_route_lo[1] |-> PC_OUT[0] == EXT_DATA_OUT[15]
                                 && EXT_DATA_IN[15] == pc_sync[0])
    else $error("bank C pin 0 not on bus data 15");
  a_c_gpio_low: assert property (!c_route_lo[31] |-> PC_OUT[15] == c_dout[15]
                                 && EXT_DATA_IN[0] == 1'b0)
    else $error("bank C pin 15 not on GPIO");
  a_c_addr_map: assert property (c_route_hi[1] |->
                                 PC_OE[16] && PC_OUT[16] == EXT_ADDR_HI[0])
    else $error("bank C pin 16 not driving address 8");
  a_c_gpio_high: assert property (!c_route_hi[15] |-> PC_OUT[23] == c_dout[23])
    else $error("bank C pin 23 not on GPIO");
  a_fsel_reset: assert property ($rose(rst_n) |-> b_fsel_lo == '0 && b_fsel_hi == '0)
    else $error("filter selectors not cleared by reset");
  a_raw_pass: assert property (b_fsel_lo[9:8] == FLT_RAW && sel_one[4] |->
                               ONE_IN[4] == PB_IN[4])
    else $error("raw mode did not pass pin");
  a_sync_lag: assert property (b_fsel_lo[7:6] == FLT_SYNC [*3] |->
                               b_qual[3] == $past(PB_IN[3], 2))
    else $error("sync mode lag is not two cycles");
  a_idle_level: assert property (!sel_two[5] |-> TWO_IN[5] == DEF_TWO[5])
    else $error("unrouted input left its idle level");
  a_shared_idle: assert property (cand == '0 |-> SHARED_IN == DEF_SHARED)
    else $error("shared input not at idle level");
  a_tick_space: assert property (tick[0] && b_ctrl[7:0] == 8'h01 ##1
                                 b_ctrl[7:0] == 8'h01 [*2] |-> !$past(tick[0]) && tick[0])
    else $error("sample strobe spacing wrong");
endmodule

// ===== test/pmiq_board.sv
// Board model for bank B: a pull-up on every pin, optional forced level.
// Assumes pad drive enables are active high.
module pmiq_board (
  input  wire logic [31:0] pad_out,  // Block drive value
  input  wire logic [31:0] pad_oe,   // Block drive enable
  input  wire logic [31:0] ext_lvl,  // Level forced by the board
  input  wire logic [31:0] ext_en,   // Board drive enable
  output logic [31:0]      pad_in    // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released open-drain lines float up, never hold the old value
  always_comb
    for (int i = 0; i < 32; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_lvl[i] : 1'b1);
endmodule

// ===== test/pmiq_top_tb.sv
// Bench for pmiq_top: AHB-Lite master tasks and one task per scenario.
// Assumes a zero-wait slave and the pulled-up board model on bank B.
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module pmiq_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pmiq_pkg::*;
  logic        clk = 0, rst_n = 0, hwrite = 0;  // Clock, reset, bus direction
  logic [1:0]  htrans = 0;                      // Transfer type
  logic [31:0] haddr = 0, hwdata = 0, lvl = 0, en = 0, rdv;  // Bus and board
  logic [31:0] p1o = 0, p1e = 0, p2o = 0, p2e = 0, p3o = 0, p3e = 0;  // Peripherals
  logic [23:0] pc_in = 0;                       // Bank C pins
  logic [15:0] xdo = 0, xde = 0;                // Bus data unit
  logic [7:0]  xa = 0;                          // Bus address unit
  wire         hrdy, hresp, sh;
  wire  [31:0] hrdata, pb_in, pb_out, pb_oe, in1, in2, in3;
  wire  [23:0] pc_out, pc_oe;
  wire  [15:0] xdi;
  int          err_total = 0, check_count = 0;  // Mismatches, comparisons
  pmiq_top DUT (
    .CLK_SYS(clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy),
    .HRESP(hresp), .HRDATA(hrdata), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe),
    .PC_IN(pc_in), .PC_OUT(pc_out), .PC_OE(pc_oe), .ONE_OUT(p1o), .ONE_OE(p1e),
    .ONE_IN(in1), .TWO_OUT(p2o), .TWO_OE(p2e), .TWO_IN(in2), .THREE_OUT(p3o),
    .THREE_OE(p3e), .THREE_IN(in3), .SHARED_IN(sh), .EXT_DATA_OUT(xdo),
    .EXT_DATA_OE(xde), .EXT_DATA_IN(xdi), .EXT_ADDR_HI(xa));
  pmiq_board BRD (.pad_out(pb_out), .pad_oe(pb_oe), .ext_lvl(lvl), .ext_en(en),
    .pad_in(pb_in));
  always #10 clk = ~clk;
  // ----
  // Bus master
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait for hready; a hang ends the run
  task automatic wt;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin err_total++; wrap_up; end
  endtask
  task automatic wr(input logic [31:0] a, d);
    htrans <= 2'h2; haddr <= a; hwrite <= 1'b1; wt;
    htrans <= 2'h0; hwdata <= d; wt;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    htrans <= 2'h2; haddr <= a; hwrite <= 1'b0; wt;
    htrans <= 2'h0; wt;
    d = hrdata;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    rd(OFS_B_FSEL_LO, rdv); `CK(rdv, RST_REG)
    rd(OFS_B_FSEL_HI, rdv); `CK(rdv, RST_REG)
    wr(OFS_C_ROUTE_HI, 32'hFFFF_FFFF); rd(OFS_C_ROUTE_HI, rdv); `CK(rdv, C_HI_MASK)
    rd(32'h40, rdv); `CK({hresp, rdv}, 33'h0)
    $display("t_regs done");
  endtask
  // Every route code on a low and a high selector field
  task automatic t_route;
    p2o <= '1; p2e <= '1; p3o <= '1; p3e <= '1;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_B_ROUTE_LO, c << 6); wr(OFS_B_ROUTE_HI, c << 6); cyc(3);
      `CK({in3[3], in2[3], in1[3]}, (c == 0) ? 3'h0 : 3'h1 << (c - 1))
      `CK({in3[19], in2[19], in1[19]}, (c == 0) ? 3'h0 : 3'h1 << (c - 1))
      `CK({pb_oe[19], pb_out[19]}, (c >= 2) ? 2'h3 : 2'h0)
    end
    wr(OFS_B_ROUTE_LO, 32'h5); p1o <= 32'h0; cyc(1);
    `CK({pb_oe[1:0], pb_out[1:0]}, 4'hC)
    p1o <= 32'h3; cyc(4);
    `CK({pb_oe[1:0], in1[1:0]}, 4'h3)
    $display("t_route done");
  endtask
  task automatic t_bankc;
    xdo <= 16'h8001; xde <= '1; xa <= 8'h81; pc_in <= 24'h1;
    wr(OFS_C_ROUTE_LO, 32'hC000_0001); wr(OFS_C_ROUTE_HI, 32'hC001); cyc(3);
    `CK({pc_oe[15], pc_out[15], pc_oe[0]}, 3'h6)
    `CK({pc_oe[23], pc_out[23], pc_oe[16], xdi[15]}, 4'hC)
    wr(OFS_C_ROUTE_LO, 32'h2); wr(OFS_C_ROUTE_HI, 32'h2); cyc(3);
    `CK({pc_oe[0], pc_out[0], pc_oe[16], pc_out[16], xdi[15]}, 5'h1F)
    $display("t_bankc done");
  endtask
  // A glitch of g cycles is driven and the level checked low 40 cycles later; a level must take at least mk cycles
  task automatic t_filt(input logic [1:0] m, input logic [31:0] ctrl, input int g, mk);
    int k;
    wr(OFS_B_ROUTE_LO, 32'h100); wr(OFS_B_CTRL, ctrl); wr(OFS_B_FSEL_LO, 32'(m) << 8);
    en <= 32'h10; lvl <= 32'h0; cyc(40);
    lvl <= 32'h10; cyc(g); lvl <= 32'h0; cyc(40);
    `CK(in1[4], 1'b0)
    lvl <= 32'h10;
    k = 0;
    // Look at the settled level between edges, then realign to a rising edge
    do begin @(negedge clk); k++; end while (in1[4] !== 1'b1 && k < 60);
    `CK(k >= mk && k < 60, 1'b1)
    if (k >= 60) wrap_up;
    cyc(1);
    $display("t_filt done");
  endtask
  task automatic t_raw;
    wr(OFS_B_FSEL_LO, 32'h300); lvl <= 32'h0; @(negedge clk);
    `CK(in1[4], 1'b0)
    cyc(1); wr(OFS_B_FSEL_LO, 32'h0); lvl <= 32'h10; cyc(1);
    `CK(in1[4], 1'b0)
    cyc(2);
    `CK(in1[4], 1'b1)
    $display("t_raw done");
  endtask
  // Pins 2 and 5 both feed the shared input
  task automatic t_share;
    en <= 32'h24; lvl <= 32'h4; wr(OFS_B_ROUTE_LO, 32'h0); cyc(3);
    `CK(sh, 1'b1)
    wr(OFS_B_ROUTE_LO, 32'h400); cyc(3);
    `CK(sh, 1'b0)
    wr(OFS_B_ROUTE_LO, 32'h410); cyc(3);
    `CK(sh, 1'b1)
    $display("t_share done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    t_regs; t_route; t_bankc;
    t_filt(FLT_WIN3, 32'h0, 2, 5);
    t_filt(FLT_WIN6, 32'hFFFF_FF00, 5, 8);
    t_filt(FLT_WIN6, 32'h1, 9, 12);
    t_raw; t_share;
    wrap_up;
  end
endmodule
